// [common/ptm_pkg.sv]
// Package for the power and thermal manager: states, trip encodings, timing counts.
// Assumes a single 250 MHz core clock; all times are converted to cycles here.
package ptm_pkg;

    localparam int unsigned CLK_PERIOD_PS      = 4000;
    localparam int unsigned TEMP_W             = 8;
    // High trip sits this many degrees below the catastrophic point
    localparam logic [7:0]  HIGH_TRIP_OFFSET   = 8'h0E;
    localparam logic [7:0]  CAT_TRIP_RESET     = 8'h7F;
    // I/O idle time before sense amps are disabled, in ns, and its cycle count
    localparam int unsigned IO_IDLE_NS         = 40;
    localparam int unsigned IO_IDLE_CYCLES     = (IO_IDLE_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [3:0]  IO_IDLE_COUNT      = 4'(IO_IDLE_CYCLES);

    typedef enum logic [1:0] {
        PTM_C0,
        PTM_SLEEP,
        PTM_WAKE
    } ptm_cstate_t;

endpackage : ptm_pkg

// [src/ptm_sync.sv]
// Two-flop synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to clock.
`timescale 1ns/1ps
module ptm_sync
    import ptm_pkg::*;
(
    input  wire logic clock,   // Core clock
    input  wire logic rst_b,   // Async reset, active low
    input  wire logic rst_val, // Unused; reset level is fixed at one (tied constant by parent)
    input  wire logic d_in,    // Asynchronous level
    output logic      q_out    // Synchronised level
);
    typedef struct packed {
        logic s1;
        logic s2;
    } ptm_sync_st_t;

    ptm_sync_st_t st_reg;
    ptm_sync_st_t st_next;

    always_comb
    begin
        st_next    = st_reg;
        st_next.s1 = d_in;
        st_next.s2 = st_reg.s1;
    end

    // Reset value is one: the pin it guards idles high
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            st_reg <= '{s1: 1'b1, s2: 1'b1};
        else
            st_reg <= st_next;
    end

    assign q_out = st_reg.s2;

    logic unused_rst_val;
    assign unused_rst_val = rst_val;

endmodule : ptm_sync

// [src/ptm_power_thermal.sv]
// Processor sleep control and thermal protection of the memory hub.
// Assumes the sensor reading arrives already on the core clock and that
// deep_sleep_in and ext_overtemp_n are asynchronous pins.
`timescale 1ns/1ps
module ptm_power_thermal
    import ptm_pkg::*;
(
    input  wire logic              clock,          // 250 MHz core clock
    input  wire logic              rst_b,          // Async reset, active low
    input  wire logic              lvl3_read,      // Pulse: software read of level-3 register
    input  wire logic              wake_event,     // Pulse: break event back to full-on
    input  wire logic              deep_sleep_in,  // Deep-sleep pin, active high
    input  wire logic              pll_off_en,     // PLL shut-off allowed in deep sleep
    input  wire logic              cat_wr,         // Pulse: write catastrophic trip
    input  wire logic [TEMP_W-1:0] cat_wr_data,    // Catastrophic trip value
    input  wire logic              cat_lock_set,   // Pulse: lock catastrophic trip
    input  wire logic [TEMP_W-1:0] temp_now,       // On-die sensor reading
    input  wire logic              high_irq_en,    // Interrupt on high-trip crossing
    input  wire logic              hw_throt_en,    // Throttle above high trip
    input  wire logic              ext_irq_en,     // Over-temp pin raises interrupt
    input  wire logic              ext_throt_en,   // Over-temp pin throttles reads
    input  wire logic              ext_overtemp_n, // Over-temp pin, active low, asynchronous
    input  wire logic              io_busy,        // Memory I/O has traffic
    input  wire logic              irq_ack,        // Pulse: clear latched interrupt
    output logic                   in_sleep,       // Processor in sleep state
    output logic                   self_refresh,   // Memory in self-refresh
    output logic                   host_pll_off,   // Host clock PLL shut off
    output logic [TEMP_W-1:0]      cat_trip,       // Catastrophic trip value
    output logic                   cat_locked,     // Catastrophic trip locked
    output logic                   cat_shutdown,   // At or above catastrophic point
    output logic                   thermal_irq,    // Latched thermal interrupt
    output logic                   hw_throttle,    // Core throttle
    output logic                   read_throttle,  // Read throttle for all modules
    output logic                   sense_amp_en,   // Input sense amps enabled
    output logic                   out_buf_oe      // Output buffers driving
);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        ptm_cstate_t       cstate;
        logic              slp;
        logic              srf;
        logic              pll_off;
        logic [TEMP_W-1:0] cat;
        logic              locked;
        logic              cat_hot;
        logic              above_high;
        logic              irq;
        logic              hw_thr;
        logic              rd_thr;
        logic [3:0]        idle_cnt;
        logic              io_on;
    } ptm_st_t;

    ptm_st_t st_reg;
    ptm_st_t st_next;
    logic    ext_hot_n;
    logic    dslp_s;

    function automatic logic [TEMP_W-1:0] high_point(input logic [TEMP_W-1:0] cat_v);
        high_point = (cat_v > HIGH_TRIP_OFFSET) ? cat_v - HIGH_TRIP_OFFSET : '0;
    endfunction : high_point

    ////////////////////////////////////////////////////////////////////////////
    ptm_sync u_sync_ext (
        .clock   (clock),
        .rst_b   (rst_b),
        .rst_val (1'b1),
        .d_in    (ext_overtemp_n),
        .q_out   (ext_hot_n)
    );

    ptm_sync u_sync_dslp (
        .clock   (clock),
        .rst_b   (rst_b),
        .rst_val (1'b1),
        .d_in    (~deep_sleep_in),
        .q_out   (dslp_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic ext_hot;
        logic now_high;
        ext_hot  = 1'b0;
        now_high = 1'b0;
        st_next  = st_reg;

        // Deeper sleep uses the same state; the pin only steers the PLL
        case (st_reg.cstate)
            PTM_C0:
            begin
                if (lvl3_read)
                    st_next.cstate = PTM_SLEEP;
            end
            PTM_SLEEP:
            begin
                if (wake_event)
                    st_next.cstate = PTM_WAKE;
            end
            PTM_WAKE:
            begin
                // One cycle for the PLL to restart before leaving self-refresh
                st_next.cstate = PTM_C0;
            end
            default:
            begin
                st_next.cstate = PTM_C0;
            end
        endcase

        // Decoded here so that the state outputs come straight from flops
        st_next.slp     = (st_next.cstate == PTM_SLEEP);
        st_next.srf     = (st_next.cstate != PTM_C0);
        st_next.pll_off = (st_next.cstate == PTM_SLEEP) && pll_off_en && !dslp_s;

        if (cat_wr && !st_reg.locked)
            st_next.cat = cat_wr_data;
        if (cat_lock_set)
            st_next.locked = 1'b1;
        st_next.cat_hot = temp_now >= st_reg.cat;

        now_high           = temp_now >= high_point(st_reg.cat);
        st_next.above_high = now_high;
        ext_hot            = !ext_hot_n;

        // A new event wins over a clear in the same cycle
        if (irq_ack)
            st_next.irq = 1'b0;
        if ((high_irq_en && (now_high != st_reg.above_high))
            || (ext_irq_en && ext_hot))
            st_next.irq = 1'b1;

        st_next.hw_thr = hw_throt_en && now_high;
        st_next.rd_thr = ext_throt_en && ext_hot;

        // Idle I/O powers down after a short quiet period
        if (io_busy && st_next.cstate == PTM_C0)
        begin
            st_next.idle_cnt = IO_IDLE_COUNT;
            st_next.io_on    = 1'b1;
        end
        else if (st_reg.idle_cnt != 4'h0)
            st_next.idle_cnt = st_reg.idle_cnt - 4'h1;
        else
            st_next.io_on = 1'b0;
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            st_reg <= '{cstate: PTM_C0, slp: 1'b0, srf: 1'b0, pll_off: 1'b0, cat: CAT_TRIP_RESET,
                        locked: 1'b0, cat_hot: 1'b0, above_high: 1'b0, irq: 1'b0, hw_thr: 1'b0,
                        rd_thr: 1'b0, idle_cnt: 4'h0, io_on: 1'b0};
        else
            st_reg <= st_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    assign in_sleep      = st_reg.slp;
    assign self_refresh  = st_reg.srf;
    assign host_pll_off  = st_reg.pll_off;
    assign cat_trip      = st_reg.cat;
    assign cat_locked    = st_reg.locked;
    assign cat_shutdown  = st_reg.cat_hot;
    assign thermal_irq   = st_reg.irq;
    assign hw_throttle   = st_reg.hw_thr;
    assign read_throttle = st_reg.rd_thr;
    assign sense_amp_en  = st_reg.io_on;
    assign out_buf_oe    = st_reg.io_on;

    ////////////////////////////////////////////////////////////////////////////
    chk_sleep_entry: assert property (@(posedge clock) disable iff (!rst_b)
        (st_reg.cstate == PTM_C0 && lvl3_read) |=> in_sleep)
        else $error("level-3 read did not enter sleep");

    chk_refresh_sleep: assert property (@(posedge clock) disable iff (!rst_b)
        in_sleep |-> self_refresh)
        else $error("sleep without self-refresh");

    chk_pll_off: assert property (@(posedge clock) disable iff (!rst_b)
        host_pll_off |-> in_sleep && $past(pll_off_en))
        else $error("PLL off outside enabled sleep");

    chk_cat_lock: assert property (@(posedge clock) disable iff (!rst_b)
        $past(cat_locked) |-> $stable(cat_trip))
        else $error("locked trip changed");

    chk_high_cross: assert property (@(posedge clock) disable iff (!rst_b)
        (high_irq_en && st_reg.above_high != (temp_now >= high_point(cat_trip)))
        |=> thermal_irq)
        else $error("high trip crossing lost");

    chk_hw_throt: assert property (@(posedge clock) disable iff (!rst_b)
        hw_throttle |-> $past(hw_throt_en))
        else $error("throttle without enable");

    chk_ext_throt: assert property (@(posedge clock) disable iff (!rst_b)
        (ext_throt_en && !ext_hot_n) |=> read_throttle)
        else $error("over-temp did not throttle reads");

    chk_ext_sync: assert property (@(posedge clock) disable iff (!rst_b)
        $fell(ext_hot_n) |-> $past(!ext_overtemp_n, 2))
        else $error("over-temp bypassed synchroniser");

    chk_io_idle: assert property (@(posedge clock) disable iff (!rst_b)
        in_sleep [*8] ##1 in_sleep [*3] |-> !out_buf_oe)
        else $error("buffers on during long sleep");

endmodule : ptm_power_thermal

// [testbench/ptm_sensor_model.sv]
// Behavioural external thermal sensor with an open-drain over-temperature output.
// Assumes a board pull-up on the pin; the bench feeds the module temperature.
`timescale 1ns/1ps
module ptm_sensor_model
    import ptm_pkg::*;
#(
    parameter logic [7:0] HOT_ON  = 8'h50,  // Assert at or above
    parameter logic [7:0] HOT_OFF = 8'h4C   // Release below
)
(
    input  wire logic              clock,          // Sample clock
    input  wire logic [TEMP_W-1:0] dimm_temp,      // Module temperature
    output wire logic              ext_overtemp_n  // Open drain, pulled up
);
    logic pull_low = 1'b0;

    // Own hysteresis band, since the hub adds none
    always @(posedge clock)
    begin
        if (dimm_temp >= HOT_ON)
            pull_low <= 1'b1;
        else if (dimm_temp < HOT_OFF)
            pull_low <= 1'b0;
    end
    // Released pin rises to the pull-up level
    assign ext_overtemp_n = pull_low ? 1'b0 : 1'b1;
endmodule : ptm_sensor_model

// [testbench/power_thermal_manager_bench.sv]
// Self-checking bench for the power and thermal manager.
// Assumes the design modules and ptm_pkg are compiled first.
`timescale 1ns/1ps
module power_thermal_manager_bench
    import ptm_pkg::*;
;
    logic clock, rst_b = 0, lvl3_read = 0, wake_event = 0, deep_sleep_in = 0;
    logic pll_off_en = 0, cat_wr = 0, cat_lock_set = 0, high_irq_en = 0;
    logic hw_throt_en = 0, io_busy = 0, irq_ack = 0, ovt_n, ext_irq_en = 0, ext_throt_en = 0;
    logic [7:0] cat_wr_data = 8'h00, temp_now = 8'h30, dimm_temp = 8'h30, cat_trip;
    logic in_sleep, self_refresh, host_pll_off, cat_locked, cat_shutdown;
    logic thermal_irq, hw_throttle, read_throttle, sense_amp_en, out_buf_oe;
    int miscompares = 0, checks = 0, cycles = 0;
    // Row: temperature, throttle enable, expected throttle, expected shutdown
    logic [10:0] rows [4] = '{{8'h30, 3'b100}, {8'h58, 3'b110}, {8'h58, 3'b000},
                              {8'h60, 3'b111}};

    ptm_power_thermal uut (.clock(clock), .rst_b(rst_b), .lvl3_read(lvl3_read),
        .wake_event(wake_event), .deep_sleep_in(deep_sleep_in), .pll_off_en(pll_off_en),
        .cat_wr(cat_wr), .cat_wr_data(cat_wr_data), .cat_lock_set(cat_lock_set),
        .temp_now(temp_now), .high_irq_en(high_irq_en), .hw_throt_en(hw_throt_en),
        .ext_irq_en(ext_irq_en), .ext_throt_en(ext_throt_en), .ext_overtemp_n(ovt_n),
        .io_busy(io_busy), .irq_ack(irq_ack),
        .in_sleep(in_sleep), .self_refresh(self_refresh), .host_pll_off(host_pll_off),
        .cat_trip(cat_trip), .cat_locked(cat_locked), .cat_shutdown(cat_shutdown),
        .thermal_irq(thermal_irq), .hw_throttle(hw_throttle), .read_throttle(read_throttle),
        .sense_amp_en(sense_amp_en), .out_buf_oe(out_buf_oe));
    ptm_sensor_model sensor (.clock(clock), .dimm_temp(dimm_temp), .ext_overtemp_n(ovt_n));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    initial
    begin
        clock = 0;
        forever #2 clock = ~clock;
    end

    // Hang guard, far above the roughly 120 cycles the sequence needs
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        cyc(2);
        check("cat_trip", cat_trip, 8'h7F);
        check("in_sleep", in_sleep, 8'h00);
        @(posedge clock) rst_b <= 1;
        @(posedge clock) {cat_wr, cat_wr_data} <= {1'b1, 8'h60};
        @(posedge clock) {cat_wr, cat_lock_set} <= 2'b01;
        @(posedge clock) {cat_lock_set, cat_wr, cat_wr_data} <= {2'b01, 8'h20};
        @(posedge clock) cat_wr <= 0;
        cyc(2);
        check("cat_trip", cat_trip, 8'h60);
        check("cat_locked", cat_locked, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clock) {temp_now, hw_throt_en} <= rows[i][10:2];
            cyc(3);
            check("hw_throttle", hw_throttle, 8'(rows[i][1]));
            check("cat_shutdown", cat_shutdown, 8'(rows[i][0]));
        end
        // Crossing the high trip upward, then downward, each raise the interrupt
        @(posedge clock) {temp_now, irq_ack} <= {8'h30, 1'b1};
        @(posedge clock) {high_irq_en, irq_ack, temp_now} <= {2'b10, 8'h58};
        cyc(3);
        check("thermal_irq", thermal_irq, 8'h01);
        @(posedge clock) irq_ack <= 1;
        @(posedge clock) irq_ack <= 0;
        cyc(2);
        check("thermal_irq", thermal_irq, 8'h00);
        @(posedge clock) temp_now <= 8'h30;
        cyc(3);
        check("thermal_irq", thermal_irq, 8'h01);
        // Last traffic just before sleep, so the idle count runs down while asleep
        @(posedge clock) io_busy <= 1;
        @(posedge clock) {lvl3_read, io_busy} <= 2'b10;
        @(posedge clock) lvl3_read <= 0;
        cyc(1);
        check("in_sleep", in_sleep, 8'h01);
        check("self_refresh", self_refresh, 8'h01);
        @(posedge clock) {pll_off_en, deep_sleep_in} <= 2'b11;
        cyc(12);
        check("host_pll_off", host_pll_off, 8'h01);
        check("self_refresh", self_refresh, 8'h01);
        check("sense_amp_en", sense_amp_en, 8'h00);
        @(posedge clock) {deep_sleep_in, wake_event} <= 2'b01;
        @(posedge clock) wake_event <= 0;
        cyc(4);
        check("in_sleep", in_sleep, 8'h00);
        check("host_pll_off", host_pll_off, 8'h00);
        check("self_refresh", self_refresh, 8'h00);
        @(posedge clock) io_busy <= 1;
        cyc(3);
        check("sense_amp_en", sense_amp_en, 8'h01);
        check("out_buf_oe", out_buf_oe, 8'h01);
        @(posedge clock) io_busy <= 0;
        cyc(IO_IDLE_CYCLES + 4);
        check("sense_amp_en", sense_amp_en, 8'h00);
        check("out_buf_oe", out_buf_oe, 8'h00);
        // Pin falls one edge after the temperature, then two sync flops, then the flag
        @(posedge clock) {ext_irq_en, ext_throt_en} <= 2'b11;
        foreach (rows[i])
        begin
            @(posedge clock) dimm_temp <= (i == 0) ? 8'h55 : (i == 1) ? 8'h4E : 8'h40;
            cyc(3);
            check("read_throttle", read_throttle, (i == 1 || i == 2) ? 8'h01 : 8'h00);
            cyc(2);
            check("read_throttle", read_throttle, (i < 2) ? 8'h01 : 8'h00);
            @(posedge clock) irq_ack <= 1;
            @(posedge clock) irq_ack <= 0;
            cyc(1);
            check("thermal_irq", thermal_irq, (i < 2) ? 8'h01 : 8'h00);
        end
        // Reset in mid-run drops the lock and restores the trip default
        @(posedge clock) rst_b <= 0;
        cyc(1);
        check("cat_trip", cat_trip, 8'h7F);
        check("thermal_irq", thermal_irq, 8'h00);
        @(posedge clock) rst_b <= 1;
        cyc(2);
        check("cat_locked", cat_locked, 8'h00);
        check("in_sleep", in_sleep, 8'h00);
        complete_run();
    end
endmodule : power_thermal_manager_bench
